// ### verification/pmsc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module pmsc_host_model (
    // Command.
    input wire logic go,
    input wire logic [7:0] data_v,
    // Bus.
    input wire logic sda_oe,
    output logic scl,
    output logic sda,
    output logic busy
);
    logic drive_low = 1'b0;
    // The board pull-up makes the line high unless some party pulls it.
    assign sda = !(drive_low || sda_oe);
    initial scl = 1'b1;
    initial busy = 1'b0;
    // The bus clock stands high between frames.
    always @(posedge go) begin
        busy = 1'b1;
        #13 drive_low = 1'b1;
        #80;
        for (int i = 7; i >= -1; i--) begin
            scl = 1'b0;
            #40 drive_low = (i >= 0) ? !data_v[i] : 1'b0;
            #40 scl = 1'b1;
            #80;
        end
        scl = 1'b0;
        #40 drive_low = 1'b1;
        #40 scl = 1'b1;
        #40 drive_low = 1'b0;
        #40 busy = 1'b0;
    end
endmodule : pmsc_host_model

`default_nettype wire

// ### verification/pmsc_sideband_checker.sv
`timescale 1ns/100ps
`default_nettype none

module pmsc_sideband_checker
    import pmsc_pkg::*;
#(
    parameter logic [31:0] INIT_CYCLES = PMSC_INIT_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Host pins.
    input wire logic module_select_n,
    input wire logic module_select_n_driven,
    input wire logic module_reset_n,
    input wire logic low_power_request,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic attention_n_out,
    input wire logic attention_n_oe,
    input wire logic module_present_n,
    // Module internals.
    input wire logic fault_event,
    input wire logic flags_read,
    input wire logic slave_sda_pull,
    input wire logic slave_selected,
    input wire logic slave_scl,
    input wire logic slave_sda,
    input wire logic settings_reset,
    input wire logic data_not_ready,
    input wire logic reduced_power
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // =====================================================================
    // Pulse and init counters
    // =====================================================================
    localparam logic [31:0] LONG_LOW = PMSC_RESET_MIN_CYCLES + 32'h0000_0003;
    localparam logic [31:0] SHORT_LOW = PMSC_RESET_MIN_CYCLES - 32'h0000_0003;
    logic [31:0] low_cnt;
    logic [31:0] init_cnt;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            low_cnt <= 32'h0000_0000;
            init_cnt <= 32'h0000_0000;
        end else begin
            low_cnt <= module_reset_n ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
            init_cnt <= settings_reset ? 32'h0000_0000 : init_cnt + 32'h0000_0001;
        end
    end
    // =====================================================================
    // Properties
    // =====================================================================
    sequence s_long_release;
        $rose(module_reset_n) && low_cnt >= LONG_LOW && !data_not_ready;
    endsequence
    sequence s_restore;
        ##[2:6] settings_reset ##1 (!settings_reset && data_not_ready);
    endsequence
    a_desel_quiet: assert property (!slave_selected |->
        slave_scl && slave_sda && !sda_oe)
        else $error("deselected module touches the bus");
    a_sel_follow: assert property (
        (!module_select_n && module_select_n_driven)[*4] |-> slave_selected)
        else $error("held select not taken");
    a_undriven_desel: assert property ((!module_select_n_driven)[*4] |-> !slave_selected)
        else $error("floating select reads selected");
    a_pull_follow: assert property (slave_selected |-> sda_oe == $past(slave_sda_pull))
        else $error("data pull not passed to pin");
    a_bus_follow: assert property (slave_selected |->
        slave_scl == $past(scl_in, 3) && slave_sda == $past(sda_in, 3))
        else $error("selected bus levels not passed to slave");
    a_pins_static: assert property (
        !attention_n_out && !sda_out && !module_present_n)
        else $error("pin driven high or presence lost");
    a_lp_follow: assert property ($past(nrst, 3) |->
        reduced_power == $past(low_power_request, 3))
        else $error("reduced power does not follow request");
    a_long_reset: assert property (s_long_release |-> s_restore)
        else $error("long reset pulse not obeyed");
    a_short_ignored: assert property ($rose(module_reset_n) && low_cnt < SHORT_LOW
        && !data_not_ready |-> (!settings_reset)[*8])
        else $error("short reset pulse obeyed");
    a_done_attn: assert property ($fell(data_not_ready) |-> attention_n_oe
        && init_cnt >= INIT_CYCLES - 32'h0000_0003 && init_cnt <= INIT_CYCLES + 32'h0000_0002)
        else $error("completion timing or attention wrong");
    a_fault_attn: assert property (fault_event && !data_not_ready |->
        ##[1:2] attention_n_oe)
        else $error("fault not reported");
    a_read_clears: assert property (flags_read && !fault_event && !data_not_ready |->
        ##2 !attention_n_oe)
        else $error("attention not released after flag read");
endmodule : pmsc_sideband_checker

bind pmsc_sideband pmsc_sideband_checker #(.INIT_CYCLES(INIT_CYCLES)) i_chk (.*);

`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    import pmsc_pkg::*;
    localparam logic [31:0] INIT = 32'h0000_0032;
    logic clock = 0, nrst = 0, sel_n = 1, sel_drv = 1, rst_n = 1, lp = 0;
    logic fault = 0, fread = 0, pull = 0, go = 0, exp_sel = 0, exp_lp = 0, e;
    logic p_sel = 0, p_lp = 0, p_att = 0;
    logic [7:0] dat = 8'h00;
    logic [31:0] v;
    logic scl, sda, busy, sda_out, sda_oe, att_out, att_oe, prs_n;
    logic s_sel, s_scl, s_sda, set_rst, dnr, rp;
    logic q_sel[$], q_lp[$], q_rst[$], q_att[$];
    int miscompares = 0, n_tests = 0;

    pmsc_sideband #(.INIT_CYCLES(INIT)) i_dut (.clock(clock), .nrst(nrst),
        .module_select_n(sel_n), .module_select_n_driven(sel_drv),
        .module_reset_n(rst_n), .low_power_request(lp), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .attention_n_out(att_out),
        .attention_n_oe(att_oe), .module_present_n(prs_n), .fault_event(fault),
        .flags_read(fread), .slave_sda_pull(pull), .slave_selected(s_sel),
        .slave_scl(s_scl), .slave_sda(s_sda), .settings_reset(set_rst),
        .data_not_ready(dnr), .reduced_power(rp));
    pmsc_host_model i_host (.go(go), .data_v(dat), .sda_oe(sda_oe), .scl(scl),
        .sda(sda), .busy(busy));

    initial forever #2.5 clock = ~clock;

    // =====================================================================
    // Checking
    // =====================================================================
    task automatic cmp(input string nm, ref logic q[$], input logic got);
        n_tests++;
        if (q.size() == 0 || q[0] !== got) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", nm, q.size() ? q[0] : 1'bx, got);
        end
        if (q.size() != 0) void'(q.pop_front());
    endtask : cmp

    always @(negedge clock) begin
        if (nrst) begin
            if (s_sel !== p_sel) cmp("slave_selected", q_sel, s_sel);
            if (rp !== p_lp) cmp("reduced_power", q_lp, rp);
            if (set_rst) cmp("data_not_ready at restore", q_rst, dnr);
            if (att_oe && !p_att) cmp("data_not_ready at attention", q_att, dnr);
        end
        p_sel = s_sel;
        p_lp = rp;
        p_att = att_oe;
    end

    task automatic complete_run;
        miscompares += q_sel.size() + q_lp.size() + q_rst.size() + q_att.size();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        complete_run();
    end

    // =====================================================================
    // Stimulus
    // =====================================================================
    task automatic wait_att(input int lim);
        for (int i = 0; i < lim && att_oe !== 1'b1; i++) @(posedge clock);
        @(posedge clock) fread <= 1'b1;
        @(posedge clock) fread <= 1'b0;
    endtask : wait_att

    task automatic frame(input logic [7:0] d);
        @(posedge clock) dat <= d;
        go <= 1'b1;
        repeat (2) @(posedge clock) go <= 1'b0;
        for (int i = 0; i < 600 && busy; i++) @(posedge clock);
    endtask : frame

    initial begin
        void'($urandom(12));
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        q_att.push_back(1'b0);
        wait_att(INIT + 20);
        $display("test power-up done");
        for (int k = 0; k < 8; k++) begin
            @(posedge clock);
            v = $urandom;
            if (k == 0) v[2:0] = 3'h6;
            sel_n <= v[0];
            sel_drv <= v[1];
            pull <= v[2];
            lp <= v[3];
            e = v[1] && !v[0];
            if (e !== exp_sel) q_sel.push_back(e);
            if (v[3] !== exp_lp) q_lp.push_back(v[3]);
            exp_sel = e;
            exp_lp = v[3];
            frame(v[15:8]);
        end
        $display("test select done");
        q_att.push_back(1'b0);
        @(posedge clock) fault <= 1'b1;
        @(posedge clock) fault <= 1'b0;
        wait_att(10);
        $display("test fault done");
        @(posedge clock) rst_n <= 1'b0;
        repeat (1000) @(posedge clock);
        rst_n <= 1'b1;
        repeat (20) @(posedge clock);
        $display("test short reset done");
        q_rst.push_back(1'b1);
        q_att.push_back(1'b0);
        rst_n <= 1'b0;
        repeat (2010) @(posedge clock);
        rst_n <= 1'b1;
        repeat (10) @(posedge clock);
        wait_att(INIT + 20);
        $display("test long reset done");
        complete_run();
    end
endmodule : tb

`default_nettype wire

// ### verilog/pmsc_bus_gate.sv
`timescale 1ns/100ps
`default_nettype none

module pmsc_bus_gate
    import pmsc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Pins.
    input wire logic module_select_n,
    input wire logic module_select_n_driven,
    input wire logic scl_in,
    input wire logic sda_in,
    // Core side.
    pmsc_bus_if.gate bus
);

    // ========================================================================
    // Synchronisers
    // ========================================================================
    logic [3:0] meta;
    logic [3:0] sync;
    logic select_level;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta <= 4'hF;
            sync <= 4'hF;
        end else begin
            meta <= {module_select_n_driven, module_select_n, scl_in, sda_in};
            sync <= meta;
        end
    end

    // ========================================================================
    // Gating
    // ========================================================================
    // An undriven select pin floats high through the internal pull-up.
    // The pull-up is resolved after the synchroniser, so no raw pin feeds logic.
    assign select_level = sync[3] ? sync[2] : 1'b1; // [R3]
    // Deselected, the slave sees an idle bus, so it can neither start nor answer.
    assign bus.selected = ~select_level; // [R1] [R2]
    assign bus.scl = select_level ? 1'b1 : sync[1]; // [R2]
    assign bus.sda = select_level ? 1'b1 : sync[0]; // [R2]

endmodule : pmsc_bus_gate

`default_nettype wire

// ### verilog/pmsc_bus_if.sv
`timescale 1ns/100ps
`default_nettype none

interface pmsc_bus_if;
    logic selected;
    logic scl;
    logic sda;
    logic sda_pull;

    modport gate (
        output selected,
        output scl,
        output sda,
        input sda_pull
    );

    modport core (
        input selected,
        input scl,
        input sda,
        output sda_pull
    );
endinterface : pmsc_bus_if

`default_nettype wire

// ### verilog/pmsc_pkg.sv
package pmsc_pkg;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam longint unsigned PMSC_CLK_PERIOD_NS = 64'h0000_0000_0000_0005;
    localparam longint unsigned PMSC_INIT_TIME_MS = 64'h0000_0000_0000_07D0;
    localparam longint unsigned PMSC_INIT_CYCLES_L =
        (PMSC_INIT_TIME_MS * 64'h0000_0000_000F_4240) / PMSC_CLK_PERIOD_NS;
    localparam logic [31:0] PMSC_INIT_CYCLES = PMSC_INIT_CYCLES_L[31:0];
    // Shortest low pulse on the reset pin that counts as a reset.
    localparam longint unsigned PMSC_RESET_MIN_NS = 64'h0000_0000_0000_2710;
    localparam longint unsigned PMSC_RESET_MIN_CYCLES_L =
        (PMSC_RESET_MIN_NS + PMSC_CLK_PERIOD_NS - 64'h0000_0000_0000_0001) / PMSC_CLK_PERIOD_NS;
    localparam logic [31:0] PMSC_RESET_MIN_CYCLES = PMSC_RESET_MIN_CYCLES_L[31:0];

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic PMSC_SYNC_RESET_HIGH = 1'b1;
    localparam logic PMSC_SYNC_RESET_LOW = 1'b0;
    localparam logic [31:0] PMSC_COUNT_ZERO = 32'h0000_0000;
    localparam logic [31:0] PMSC_COUNT_ONE = 32'h0000_0001;

    // ========================================================================
    // States
    // ========================================================================
    typedef enum logic [1:0] {
        PMSC_ST_POWERUP = 2'b00,
        PMSC_ST_READY = 2'b01,
        PMSC_ST_RESET_LOW = 2'b10,
        PMSC_ST_INIT = 2'b11
    } pmsc_state_t;

endpackage : pmsc_pkg

// ### verilog/pmsc_sideband.sv
// Functional notes
// R1 - Selected module answers management bus traffic.
// R2 - Deselected module ignores all bus traffic.
// R3 - Undriven select pin reads deselected.
// R4 - Long reset pulse restores default settings. Timed from ready state only; a pulse released in power-up or init is ignored.
// R5 - Init interval starts at reset release.
// R6 - Host ignores status until completion.
// R7 - Completion: attention asserted, not-ready negated.
// R8 - Power-up posts completion attention unasked.
// R9 - Low-power request enters reduced-power state.
// R10 - Presence output low while seated.
// R11 - Attention low reports fault or critical status.
// R12 - Host reads bus to find cause.
// R13 - Attention pin only pulled low or released.
// R14 - Host reads flag bytes after attention.
// R15 - Fully functional within 2000 ms.
// R16 - Deselected module keeps data line released.
// R17 - Host holds reset high normally.
`timescale 1ns/100ps
`default_nettype none

module pmsc_sideband
    import pmsc_pkg::*;
#(
    parameter logic [31:0] INIT_CYCLES = PMSC_INIT_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Host pins.
    input wire logic module_select_n,
    input wire logic module_select_n_driven,
    input wire logic module_reset_n,
    input wire logic low_power_request,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic attention_n_out,
    output logic attention_n_oe,
    output logic module_present_n,
    // Module internals.
    input wire logic fault_event,
    input wire logic flags_read,
    input wire logic slave_sda_pull,
    output logic slave_selected,
    output logic slave_scl,
    output logic slave_sda,
    output logic settings_reset,
    output logic data_not_ready,
    output logic reduced_power
);

    // ========================================================================
    // Bus gating
    // ========================================================================
    pmsc_bus_if bus ();

    pmsc_bus_gate u_gate (
        .clock(clock),
        .nrst(nrst),
        .module_select_n(module_select_n),
        .module_select_n_driven(module_select_n_driven),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .bus(bus.gate)
    );

    assign bus.sda_pull = slave_sda_pull;

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_meta <= {PMSC_SYNC_RESET_HIGH, PMSC_SYNC_RESET_LOW};
            pin_sync <= {PMSC_SYNC_RESET_HIGH, PMSC_SYNC_RESET_LOW};
        end else begin
            pin_meta <= {module_reset_n, low_power_request};
            pin_sync <= pin_meta;
        end
    end

    logic reset_pin;
    logic lp_pin;
    assign reset_pin = pin_sync[1];
    assign lp_pin = pin_sync[0];

    // ========================================================================
    // Reset and initialisation sequencer
    // ========================================================================
    pmsc_state_t state;
    pmsc_state_t next_state;
    logic [31:0] count;
    logic [31:0] next_count;
    logic pending;
    logic next_pending;
    logic not_ready;
    logic next_not_ready;
    logic settings_pulse;
    logic next_settings_pulse;

    always_comb begin
        next_state = state;
        next_count = count;
        next_pending = pending;
        next_not_ready = not_ready;
        next_settings_pulse = 1'b0;
        case (state)
            PMSC_ST_POWERUP: begin
                // Power-up runs its own initialisation and then posts completion.
                if (count >= INIT_CYCLES - PMSC_COUNT_ONE) begin // [R15]
                    next_state = PMSC_ST_READY;
                    next_count = PMSC_COUNT_ZERO;
                    next_not_ready = 1'b0; // [R7]
                    next_pending = 1'b1; // [R8]
                end else begin
                    next_count = count + PMSC_COUNT_ONE;
                end
            end
            PMSC_ST_READY: begin
                if (!reset_pin) begin
                    next_state = PMSC_ST_RESET_LOW;
                    next_count = PMSC_COUNT_ONE;
                end
            end
            PMSC_ST_RESET_LOW: begin
                if (reset_pin) begin
                    // Short glitches are dropped; only a long pulse resets.
                    if (count >= PMSC_RESET_MIN_CYCLES) begin // [R4]
                        next_state = PMSC_ST_INIT; // [R5]
                        next_count = PMSC_COUNT_ZERO;
                        next_settings_pulse = 1'b1; // [R4]
                        next_not_ready = 1'b1; // [R6]
                        next_pending = 1'b0;
                    end else begin
                        next_state = PMSC_ST_READY;
                        next_count = PMSC_COUNT_ZERO;
                    end
                end else if (count < PMSC_RESET_MIN_CYCLES) begin
                    next_count = count + PMSC_COUNT_ONE;
                end
            end
            PMSC_ST_INIT: begin
                if (count >= INIT_CYCLES - PMSC_COUNT_ONE) begin
                    next_state = PMSC_ST_READY;
                    next_count = PMSC_COUNT_ZERO;
                    next_not_ready = 1'b0; // [R7]
                    next_pending = 1'b1; // [R7]
                end else begin
                    next_count = count + PMSC_COUNT_ONE;
                end
            end
            default: begin
                next_state = PMSC_ST_POWERUP;
                next_count = PMSC_COUNT_ZERO;
            end
        endcase
        // A fault in the same cycle as the host's flag read stays posted.
        if (state == PMSC_ST_READY) begin
            if (flags_read) begin // [R12]
                next_pending = 1'b0;
            end
            if (fault_event) begin // [R11]
                next_pending = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= PMSC_ST_POWERUP;
            count <= PMSC_COUNT_ZERO;
            pending <= 1'b0;
            not_ready <= 1'b1;
            settings_pulse <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            pending <= next_pending;
            not_ready <= next_not_ready;
            settings_pulse <= next_settings_pulse;
        end
    end

    // ========================================================================
    // Registered outputs
    // ========================================================================
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            attention_n_out <= 1'b0;
            attention_n_oe <= 1'b0;
            module_present_n <= 1'b0;
            slave_selected <= 1'b0;
            slave_scl <= 1'b1;
            slave_sda <= 1'b1;
            settings_reset <= 1'b0;
            data_not_ready <= 1'b1;
            reduced_power <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            // The data line is only ever pulled while this module is selected.
            sda_oe <= bus.selected & bus.sda_pull; // [R1] [R16]
            // Open drain: the level is always low, only the enable moves.
            attention_n_out <= 1'b0; // [R13]
            attention_n_oe <= pending; // [R11] [R7]
            // A seated module ties the presence line to ground.
            module_present_n <= 1'b0; // [R10]
            slave_selected <= bus.selected; // [R1]
            slave_scl <= bus.scl;
            slave_sda <= bus.sda;
            settings_reset <= settings_pulse; // [R4]
            data_not_ready <= not_ready; // [R7]
            reduced_power <= lp_pin; // [R9]
        end
    end

endmodule : pmsc_sideband

`default_nettype wire
